// ---- hdl/asf_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module asf_fifo
    import asf_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_o <= 1'b1;
        end else begin
            wr_ptr_q   <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
            rd_ptr_q   <= pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
            count_q    <= count_d;
            // ready comes from the next count, so the port is a flop yet never lags
            in_ready_o <= (count_d != (AW+1)'(DEPTH));
        end
    end
endmodule // asf_fifo

// ---- hdl/asf_host.sv ----
// host controller driving the strobe fifo device pins
`timescale 1ns/1ns
module asf_host
    import asf_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // user write stream, buffered
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_valid_i,
    output logic                   wr_ready_o,
    // user read request and result
    input  wire logic              rd_req_i,
    output logic      [DATA_W-1:0] rd_data_o,
    output logic                   rd_valid_o,
    // user commands, one-cycle pulses, and status levels
    input  wire logic              clear_req_i,
    input  wire logic              reread_req_i,
    output logic                   busy_o,
    output logic                   no_room_o,
    output logic                   no_data_o,
    // device pins
    output logic                   load_strobe_n_o,
    output logic      [DATA_W-1:0] input_bus_o,
    output logic                   fetch_strobe_n_o,
    input  wire logic [DATA_W-1:0] output_bus_i,
    input  wire logic              no_room_flag_n_i,
    input  wire logic              no_data_flag_n_i,
    output logic                   clear_all_n_o,
    output logic                   first_load_or_reread_n_o,
    output logic                   chain_in_n_o
);
    asf_state_type     state_q;
    asf_state_type     state_d;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [1:0]        room_sync_q;
    logic [1:0]        data_sync_q;
    logic [DATA_W-1:0] bus_meta_q;
    logic [DATA_W-1:0] bus_sync_q;
    logic              clear_pend_q;
    logic              reread_pend_q;
    logic              cleared_q;
    logic              rd_pend_q;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;

    // only the second stage of each synchroniser is looked at
    wire room_ok  = room_sync_q[1];
    wire data_ok  = data_sync_q[1];
    wire cnt_done = (cnt_q == CNT_RESET);
    wire in_idle  = (state_q == ASF_IDLE);
    wire go_clear = in_idle && clear_pend_q;
    wire go_rt    = in_idle && !clear_pend_q && reread_pend_q && cleared_q;
    // writes wait for the first clear; reads only with data reported
    wire go_wr    = in_idle && !clear_pend_q && !reread_pend_q && cleared_q
                    && fifo_valid && room_ok;
    wire go_rd    = in_idle && !clear_pend_q && !reread_pend_q && cleared_q
                    && !go_wr && rd_pend_q && data_ok;
    wire pop      = go_wr;

    asf_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (wr_data_i),
        .in_valid_i  (wr_valid_i),
        .in_ready_o  (wr_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop)
    );

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_done ? cnt_q : CNT_W'(cnt_q - 1'b1);
        case (state_q)
            ASF_IDLE: begin
                if (go_clear) begin
                    state_d = ASF_CLR_LOW;
                    cnt_d   = CLEAR_CYC;
                end else if (go_rt) begin
                    state_d = ASF_RT_LOW;
                    cnt_d   = PULSE_CYC;
                end else if (go_wr) begin
                    state_d = ASF_WR_LOW;
                    cnt_d   = PULSE_CYC;
                end else if (go_rd) begin
                    state_d = ASF_RD_LOW;
                    // extra cycles let the bus through its synchroniser
                    cnt_d   = CNT_W'(PULSE_CYC + SYNC_CYC);
                end
            end
            ASF_WR_LOW: if (cnt_done) begin
                state_d = ASF_WR_HIGH;
                cnt_d   = WR_SETTLE_CYC;
            end
            ASF_RD_LOW: if (cnt_done) begin
                state_d = ASF_RD_HIGH;
                cnt_d   = RD_SETTLE_CYC;
            end
            ASF_CLR_LOW: if (cnt_done) begin
                state_d = ASF_CLR_REC;
                cnt_d   = RD_SETTLE_CYC;
            end
            ASF_RT_LOW: if (cnt_done) begin
                state_d = ASF_CLR_REC;
                cnt_d   = RD_SETTLE_CYC;
            end
            ASF_WR_HIGH,
            ASF_RD_HIGH,
            ASF_CLR_REC: if (cnt_done) begin
                state_d = ASF_IDLE;
            end
            default: state_d = ASF_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            room_sync_q <= 2'h0;
            data_sync_q <= 2'h0;
            bus_meta_q  <= DATA_RESET;
            bus_sync_q  <= DATA_RESET;
        end else begin
            room_sync_q <= {room_sync_q[0], no_room_flag_n_i};
            data_sync_q <= {data_sync_q[0], no_data_flag_n_i};
            bus_meta_q  <= output_bus_i;
            bus_sync_q  <= bus_meta_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ASF_IDLE;
            cnt_q   <= CNT_RESET;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // pending commands: a new request beats the clear that consumes one
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clear_pend_q  <= 1'b1;
            reread_pend_q <= 1'b0;
            rd_pend_q     <= 1'b0;
            cleared_q     <= 1'b0;
        end else begin
            clear_pend_q  <= clear_req_i || (clear_pend_q && !go_clear);
            reread_pend_q <= reread_req_i || (reread_pend_q && !go_rt);
            rd_pend_q     <= rd_req_i || (rd_pend_q && !go_rd);
            cleared_q     <= cleared_q || (state_q == ASF_CLR_LOW);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_strobe_n_o          <= 1'b1;
            fetch_strobe_n_o         <= 1'b1;
            clear_all_n_o            <= 1'b1;
            first_load_or_reread_n_o <= 1'b1;
            chain_in_n_o             <= 1'b0;
            input_bus_o              <= DATA_RESET;
            rd_data_o                <= DATA_RESET;
            rd_valid_o               <= 1'b0;
            busy_o                   <= 1'b1;
            no_room_o                <= 1'b1;
            no_data_o                <= 1'b1;
        end else begin
            load_strobe_n_o          <= (state_d != ASF_WR_LOW);
            fetch_strobe_n_o         <= (state_d != ASF_RD_LOW);
            clear_all_n_o            <= (state_d != ASF_CLR_LOW);
            first_load_or_reread_n_o <= (state_d != ASF_RT_LOW);
            chain_in_n_o             <= 1'b0;
            if (pop) begin
                input_bus_o <= fifo_data;
            end
            rd_valid_o <= (state_q == ASF_RD_LOW) && cnt_done;
            if ((state_q == ASF_RD_LOW) && cnt_done) begin
                rd_data_o <= bus_sync_q;
            end
            busy_o    <= (state_d != ASF_IDLE) || clear_pend_q;
            no_room_o <= !room_ok;
            no_data_o <= !data_ok;
        end
    end

    a_data_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !load_strobe_n_o |=> $stable(input_bus_o))
        else $error("input bus changed during load strobe");
    a_load_width: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(load_strobe_n_o) |-> !load_strobe_n_o [*7])
        else $error("load strobe pulse too short");
    a_write_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(load_strobe_n_o) |-> $past(room_sync_q[1]) && cleared_q)
        else $error("write started without room or before clear");
    a_read_gated: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(fetch_strobe_n_o) |-> $past(data_sync_q[1]))
        else $error("read started without data reported");
    a_clear_strobes: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !clear_all_n_o |-> load_strobe_n_o && fetch_strobe_n_o)
        else $error("strobe low while clear asserted");
    a_clear_recover: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(clear_all_n_o) |-> (load_strobe_n_o && fetch_strobe_n_o) [*3])
        else $error("strobe low too soon after clear");
    a_reread_fetch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(first_load_or_reread_n_o) |-> fetch_strobe_n_o [*3])
        else $error("fetch low around reread rise");
    // the fall is seen one edge after launch, the result pulse one edge after its launch
    a_read_result: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(fetch_strobe_n_o) |-> ##9 rd_valid_o)
        else $error("read result not delivered on time");
    a_single_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !first_load_or_reread_n_o |-> !chain_in_n_o)
        else $error("reread used outside single mode");

    c_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(load_strobe_n_o));
    c_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rd_valid_o);
    c_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(clear_all_n_o) && cleared_q);
    c_reread: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(first_load_or_reread_n_o));
endmodule // asf_host

// ---- hdl/asf_pkg.sv ----
// constants and types for the strobe fifo host controller
package asf_pkg;
    localparam int DATA_W = 9;
    localparam int BUF_DEPTH = 16;
    localparam int CNT_W = 4;
    localparam int CLK_NS = 20;
    // slowest speed grade figures, ns
    localparam int STROBE_PULSE_NS = 120;
    localparam int STROBE_REC_NS = 20;
    localparam int CLEAR_PULSE_NS = 120;
    localparam int CLEAR_SETUP_NS = 100;
    localparam int WR_FLAG_NS = 60;
    localparam int RD_FLAG_NS = 145;
    localparam int SYNC_CYC = 2;
    // least times round up, longest flag delays round down
    localparam logic [CNT_W-1:0] PULSE_CYC =
        CNT_W'((STROBE_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] CLEAR_CYC =
        CNT_W'(((CLEAR_PULSE_NS > CLEAR_SETUP_NS ? CLEAR_PULSE_NS : CLEAR_SETUP_NS)
                + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] REC_CYC =
        CNT_W'((STROBE_REC_NS + CLK_NS - 1) / CLK_NS);
    // after a strobe rises, wait out the flag delay plus the synchroniser
    localparam logic [CNT_W-1:0] WR_SETTLE_CYC =
        CNT_W'(WR_FLAG_NS / CLK_NS + SYNC_CYC + 1);
    localparam logic [CNT_W-1:0] RD_SETTLE_CYC =
        CNT_W'(RD_FLAG_NS / CLK_NS + SYNC_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;

    typedef enum logic [2:0] {
        ASF_IDLE    = 3'b000,
        ASF_WR_LOW  = 3'b001,
        ASF_WR_HIGH = 3'b011,
        ASF_RD_LOW  = 3'b010,
        ASF_RD_HIGH = 3'b110,
        ASF_CLR_LOW = 3'b111,
        ASF_CLR_REC = 3'b101,
        ASF_RT_LOW  = 3'b100
    } asf_state_type;
endpackage

// ---- test/asf_dev_model.sv ----
// behavioural model of the strobe fifo device seen by the host
`timescale 1ns/1ns
module asf_dev_model
    import asf_pkg::*;
#(
    parameter int DEPTH    = 8,
    parameter int ACC_NS   = 110,
    parameter int SETUP_NS = 40
) (
    input  wire logic              load_strobe_n_i,
    input  wire logic [DATA_W-1:0] input_bus_i,
    input  wire logic              fetch_strobe_n_i,
    output logic      [DATA_W-1:0] output_bus_o,
    output logic                   no_room_flag_n_o,
    output logic                   no_data_flag_n_o,
    input  wire logic              clear_all_n_i,
    input  wire logic              first_load_or_reread_n_i,
    input  wire logic              chain_in_n_i,
    output int                     fault_o
);
    logic [DATA_W-1:0] mem [DEPTH];
    int                wp, rp, cnt;
    bit                clr_seen, wr_ok, rd_ok;
    time               t_lr, t_fr, t_in, t_cr, t_rr;
    initial begin
        output_bus_o = 9'h0aa;
        no_room_flag_n_o = 1'b1;
        no_data_flag_n_o = 1'b0;
        fault_o = 0;
    end
    always @(input_bus_i) t_in = $time;
    // a strobe that falls on a low flag is counted as a host fault, not only ignored
    always @(negedge load_strobe_n_i) begin
        wr_ok = no_room_flag_n_o;
        if (!wr_ok || !clr_seen || $time - t_cr < STROBE_REC_NS) fault_o++;
        if (wr_ok && cnt == DEPTH - 1) no_room_flag_n_o <= #(WR_FLAG_NS) 1'b0;
    end
    always @(posedge load_strobe_n_i) begin
        t_lr = $time;
        if (wr_ok) begin
            if ($time - t_in < SETUP_NS) fault_o++;
            mem[wp] = input_bus_i;
            wp = (wp + 1) % DEPTH;
            cnt++;
            no_data_flag_n_o <= #(WR_FLAG_NS) 1'b1;
        end
        wr_ok = 1'b0;
    end
    always @(negedge fetch_strobe_n_i) begin
        rd_ok = no_data_flag_n_o;
        if (!rd_ok || $time - t_cr < STROBE_REC_NS || $time - t_rr < STROBE_REC_NS) fault_o++;
        if (rd_ok) output_bus_o <= #(ACC_NS) mem[rp];
        if (rd_ok && cnt == 1) no_data_flag_n_o <= #(RD_FLAG_NS) 1'b0;
    end
    always @(posedge fetch_strobe_n_i) begin
        t_fr = $time;
        if (rd_ok) begin
            rp = (rp + 1) % DEPTH;
            cnt--;
            no_room_flag_n_o <= #(WR_FLAG_NS) 1'b1;
        end
        // released bus shows the inverse so a stale word cannot pass
        output_bus_o <= #5 ~output_bus_o;
        rd_ok = 1'b0;
    end
    always @(negedge clear_all_n_i) begin
        wp = 0;
        rp = 0;
        cnt = 0;
        clr_seen = 1'b1;
        no_data_flag_n_o <= 1'b0;
        no_room_flag_n_o <= 1'b1;
    end
    always @(posedge clear_all_n_i) begin
        t_cr = $time;
        if (clr_seen && (!load_strobe_n_i || !fetch_strobe_n_i || chain_in_n_i !== 1'b0
            || $time - t_lr < CLEAR_SETUP_NS || $time - t_fr < CLEAR_SETUP_NS)) fault_o++;
    end
    // rewind assumes no wrap since the last clear
    always @(negedge first_load_or_reread_n_i) begin
        rp = 0;
        cnt = wp;
        no_data_flag_n_o <= (wp != 0);
    end
    always @(posedge first_load_or_reread_n_i) begin
        t_rr = $time;
        if (clr_seen && (!fetch_strobe_n_i || $time - t_fr < CLEAR_SETUP_NS)) fault_o++;
    end
endmodule // asf_dev_model

// ---- test/asf_host_test.sv ----
// self-checking bench for the strobe fifo host controller
`timescale 1ns/1ns
module asf_host_test import asf_pkg::*;;
    localparam int DEV_DEPTH = 8;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [DATA_W-1:0] wr_data_i = '0;
    logic wr_valid_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic clear_req_i = 1'b0;
    logic reread_req_i = 1'b0;
    logic wr_ready_o, rd_valid_o, busy_o, no_room_o, no_data_o, load_strobe_n_o;
    logic fetch_strobe_n_o, no_room_flag_n_i, no_data_flag_n_i, clear_all_n_o;
    logic first_load_or_reread_n_o, chain_in_n_o;
    logic [DATA_W-1:0] rd_data_o, input_bus_o, output_bus_i;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] keep[3];
    logic [31:0] seed = 32'he917ba40;
    int err_count = 0;
    int comparisons = 0;
    int fault_cnt, n;
    bit ok;

    always #(CLK_NS / 2) ref_clk_i = ~ref_clk_i;

    asf_host dut_u (.ref_clk_i, .rst_n_i, .wr_data_i, .wr_valid_i, .wr_ready_o, .rd_req_i,
        .rd_data_o, .rd_valid_o, .clear_req_i, .reread_req_i, .busy_o, .no_room_o,
        .no_data_o, .load_strobe_n_o, .input_bus_o, .fetch_strobe_n_o, .output_bus_i,
        .no_room_flag_n_i, .no_data_flag_n_i, .clear_all_n_o, .first_load_or_reread_n_o,
        .chain_in_n_o);
    asf_dev_model #(.DEPTH(DEV_DEPTH)) dev_u (.load_strobe_n_i(load_strobe_n_o),
        .input_bus_i(input_bus_o), .fetch_strobe_n_i(fetch_strobe_n_o),
        .output_bus_o(output_bus_i), .no_room_flag_n_o(no_room_flag_n_i),
        .no_data_flag_n_o(no_data_flag_n_i), .clear_all_n_i(clear_all_n_o),
        .first_load_or_reread_n_i(first_load_or_reread_n_o), .chain_in_n_i(chain_in_n_o),
        .fault_o(fault_cnt));

    function automatic logic [DATA_W-1:0] next_word();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[DATA_W-1:0];
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic give_up(string what);
        err_count++;
        $display("wrong value %s expected done seen timeout", what);
        summarize();
    endtask
    task automatic push(logic [DATA_W-1:0] w, int bound);
        ok = 1'b0;
        wr_data_i <= w;
        wr_valid_i <= 1'b1;
        for (int i = 0; i < bound && !ok; i++) begin
            @(posedge ref_clk_i);
            ok = wr_ready_o === 1'b1;
        end
        if (ok) exp_q.push_back(w);
    endtask
    task automatic wait_rd(input int bound, output bit got);
        got = 1'b0;
        for (int i = 0; i < bound && !got; i++) begin
            @(posedge ref_clk_i);
            got = rd_valid_o === 1'b1;
        end
        if (got) check("read word", rd_data_o, exp_q.pop_front());
    endtask
    task automatic rd_one();
        bit got;
        rd_req_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_req_i <= 1'b0;
        wait_rd(2000, got);
        if (!got) give_up("read");
    endtask
    task automatic wait_idle();
        bit idle;
        idle = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        for (int i = 0; i < 300 && !idle; i++) begin
            @(posedge ref_clk_i);
            idle = busy_o === 1'b0;
        end
        if (!idle) give_up("busy");
    endtask
    task automatic pulse_cmd(bit clr);
        clear_req_i <= clr;
        reread_req_i <= !clr;
        @(posedge ref_clk_i);
        clear_req_i <= 1'b0;
        reread_req_i <= 1'b0;
        wait_idle();
    endtask

    initial begin
        bit got;
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wait_idle();
        check("empty after clear", no_data_o, 1'b1);
        check("room after clear", no_room_o, 1'b0);
        check("single device", chain_in_n_o, 1'b0);
        $display("test reset done");
        // writes and reads overlap so the device sees loads and fetches interleaved
        fork
            begin
                repeat (20) begin
                    push(next_word(), 400);
                    if (!ok) give_up("write");
                end
                wr_valid_i <= 1'b0;
            end
            repeat (20) rd_one();
        join
        $display("test stream done");
        rd_req_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_req_i <= 1'b0;
        wait_rd(100, got);
        check("read while empty", got, 1'b0);
        check("empty flag", no_data_o, 1'b1);
        push(9'h1ff, 50);
        wr_valid_i <= 1'b0;
        wait_rd(300, got);
        check("read after write", got, 1'b1);
        $display("test empty done");
        n = 0;
        ok = 1'b1;
        while (ok && n < 40) begin
            push(next_word(), 300);
            n += ok;
        end
        wr_valid_i <= 1'b0;
        check("words taken", n, DEV_DEPTH + BUF_DEPTH);
        check("no room flag", no_room_o, 1'b1);
        check("buffer refuses", wr_ready_o, 1'b0);
        repeat (n) rd_one();
        repeat (20) @(posedge ref_clk_i);
        check("drained", no_data_o, 1'b1);
        check("room again", no_room_o, 1'b0);
        $display("test fill done");
        repeat (2) push(next_word(), 50);
        wr_valid_i <= 1'b0;
        repeat (60) @(posedge ref_clk_i);
        check("holding data", no_data_o, 1'b0);
        pulse_cmd(1'b1);
        exp_q.delete();
        check("cleared", no_data_o, 1'b1);
        for (int i = 0; i < 3; i++) begin
            keep[i] = next_word();
            push(keep[i], 50);
        end
        wr_valid_i <= 1'b0;
        repeat (3) rd_one();
        exp_q = {keep[0], keep[1], keep[2]};
        pulse_cmd(1'b0);
        repeat (3) rd_one();
        $display("test clear and reread done");
        check("device faults", fault_cnt, 32'h0);
        summarize();
    end
endmodule // asf_host_test
